// *** verilog/ufa_pkg.sv ***
// constants for the user flash access block: timing figures and cycle counts
// assumes a 10 MHz core clock; link clocks come from the controlling fabric logic
package ufa_pkg;

  // ****************************************
  // clock rate
  // ****************************************
  localparam int CLK_PERIOD_NS = 100; // core clock period

  // ****************************************
  // timing figures, in their own units
  // ****************************************
  localparam int ADDR_CLK_MIN_PERIOD_NS = 100; // address register clock period floor
  localparam int DATA_CLK_MIN_PERIOD_NS = 100; // data register clock period floor
  localparam int PROGRAM_TO_BUSY_DELAY_NS = 960; // strobe rise to busy rise, max
  localparam int ERASE_TO_BUSY_DELAY_NS = 960; // strobe rise to busy rise, max
  localparam int BUSY_TO_PROGRAM_RELEASE_NS = 20; // busy fall to strobe fall, min
  localparam int BUSY_TO_ERASE_RELEASE_NS = 20; // busy fall to strobe fall, min
  localparam int PROGRAM_HOLD_NS = 0; // strobe hold past data clock edge
  localparam int PROGRAM_BUSY_LIMIT_US = 100; // longest busy pulse, program
  localparam int ERASE_BUSY_LIMIT_MS = 500; // longest busy pulse, erase
  localparam int READ_ACCESS_NS = 65; // read access time, max

  // ****************************************
  // derived cycle counts (longest times round down; busy and read access delays never below one)
  // ****************************************
  localparam int PROGRAM_TO_BUSY_CYC =
    (PROGRAM_TO_BUSY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
    PROGRAM_TO_BUSY_DELAY_NS / CLK_PERIOD_NS;
  localparam int ERASE_TO_BUSY_CYC =
    (ERASE_TO_BUSY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
    ERASE_TO_BUSY_DELAY_NS / CLK_PERIOD_NS;
  localparam int PROGRAM_BUSY_LIMIT_CYC = (PROGRAM_BUSY_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam longint ERASE_BUSY_LIMIT_CYC =
    (longint'(ERASE_BUSY_LIMIT_MS) * 64'd1000000) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_NS / CLK_PERIOD_NS < 1) ? 1 : READ_ACCESS_NS / CLK_PERIOD_NS;

  // strobe pin to busy rise: two synchroniser stages then the busy flag register
  localparam int STROBE_TO_BUSY_CYC = 3;

  // ****************************************
  // reset value and timer width
  // ****************************************
  localparam logic BUSY_RESET = 1'b0;
  localparam int TIMER_W = 32;

  // ****************************************
  // operation sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    UFA_IDLE = 2'b00,
    UFA_PROGRAM = 2'b01,
    UFA_ERASE = 2'b10,
    UFA_RELEASE = 2'b11
  } ufa_state_t;

endpackage

// *** verilog/ufa_sync.sv ***
// two-stage level synchroniser, one stage pair per bit
// assumes its input is a level that stays put for several destination clocks
`timescale 1ns/1ps
module ufa_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk_i,
  // level from another domain
  input wire logic [WIDTH-1:0] async_i,
  // synchronised level
  output logic [WIDTH-1:0] sync_o
);

  // ****************************************
  // synchroniser stages
  // ****************************************
  generate
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic meta_reg; // first stage, read only by the second
      logic stable_reg; // second stage, safe to use
      // plain two flops; no reset so nothing but the second stage sees the first
      always_ff @(posedge clk_i) begin
        meta_reg <= async_i[b];
        stable_reg <= meta_reg;
      end
      assign sync_o[b] = stable_reg;
    end
  endgenerate

endmodule

// *** verilog/ufa_flash.sv ***
// user flash block model: address and data shift registers, program and erase
// sequencer with busy flag, flip-flop storage
// assumes the fabric controller drives the two register clocks and the strobes
// and keeps shift registers still while a program or erase is under way
`timescale 1ns/1ps
module ufa_flash
  import ufa_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 16,
  parameter int PROGRAM_BUSY_CYCLES = ufa_pkg::PROGRAM_BUSY_LIMIT_CYC,
  parameter longint ERASE_BUSY_CYCLES = ufa_pkg::ERASE_BUSY_LIMIT_CYC
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // address shift register port
  input wire logic addr_clk_i,
  input wire logic addr_shift_i,
  input wire logic addr_in_i,
  // data shift register port
  input wire logic data_clk_i,
  input wire logic data_shift_i,
  input wire logic data_in_i,
  output logic data_out_o,
  // operation strobes and status
  input wire logic program_i,
  input wire logic erase_i,
  output logic busy_o
);

  import ufa_pkg::*;

  localparam int DEPTH = 1 << ADDR_W; // words of storage

  // ****************************************
  // elaboration checks
  // ****************************************
  // shift registers slice [W-2:0], so one-bit widths cannot be served
  if (ADDR_W < 2 || ADDR_W > 12 || DATA_W < 2) begin : g_bad_width
    $error("ufa_flash: unsupported address or data width");
  end
  if (PROGRAM_BUSY_CYCLES < 1 || PROGRAM_BUSY_CYCLES > PROGRAM_BUSY_LIMIT_CYC) begin : g_bad_prog
    $error("ufa_flash: program busy length outside its limit");
  end
  if (ERASE_BUSY_CYCLES < 1 || ERASE_BUSY_CYCLES > ERASE_BUSY_LIMIT_CYC) begin : g_bad_erase
    $error("ufa_flash: erase busy length outside its limit");
  end
  if (STROBE_TO_BUSY_CYC > PROGRAM_TO_BUSY_CYC ||
      STROBE_TO_BUSY_CYC > ERASE_TO_BUSY_CYC) begin : g_bad_sync
    $error("ufa_flash: busy would rise too late for the core clock");
  end

  // ****************************************
  // address shift register (address clock domain)
  // ****************************************
  logic [ADDR_W-1:0] addr_sh_reg; // target address, msb first in
  logic [ADDR_W-1:0] addr_hold_reg; // core-side copy offered for parallel load

  // shift one bit per clock, otherwise reload current address; clock rate bounded
  // by the controller, at or above 100 ns per period
  always_ff @(posedge addr_clk_i) begin
    if (addr_shift_i) begin
      addr_sh_reg <= {addr_sh_reg[ADDR_W-2:0], addr_in_i};
    end else begin
      addr_sh_reg <= addr_hold_reg;
    end
  end

  // ****************************************
  // data shift register (data clock domain)
  // ****************************************
  logic [DATA_W-1:0] data_sh_reg; // program word in, read word out
  logic [DATA_W-1:0] read_word_reg; // stored word at the synchronised address

  // shift msb out and serial bit in, or parallel load the read word
  // program strobe must stay valid through this edge, zero hold needed
  always_ff @(posedge data_clk_i) begin
    if (data_shift_i) begin
      data_sh_reg <= {data_sh_reg[DATA_W-2:0], data_in_i};
    end else begin
      data_sh_reg <= read_word_reg;
    end
  end

  // serial out is straight off the register msb
  assign data_out_o = data_sh_reg[DATA_W-1];

  // ****************************************
  // crossings into the core domain
  // ****************************************
  // address and data words are quasi-static: the controller leaves the shift
  // clocks idle around a strobe, so per-bit sync lands on a settled word
  logic [ADDR_W-1:0] addr_sync; // address seen by the core
  logic [DATA_W-1:0] data_sync; // program word seen by the core
  logic [1:0] strobe_sync; // {erase, program} seen by the core

  ufa_sync #(.WIDTH(ADDR_W)) u_addr_sync (
    .clk_i(clk_i),
    .async_i(addr_sh_reg),
    .sync_o(addr_sync)
  );

  ufa_sync #(.WIDTH(DATA_W)) u_data_sync (
    .clk_i(clk_i),
    .async_i(data_sh_reg),
    .sync_o(data_sync)
  );

  ufa_sync #(.WIDTH(2)) u_strobe_sync (
    .clk_i(clk_i),
    .async_i({erase_i, program_i}),
    .sync_o(strobe_sync)
  );

  logic program_req; // synchronised program strobe
  logic erase_req; // synchronised erase strobe
  assign program_req = strobe_sync[0];
  assign erase_req = strobe_sync[1];

  // ****************************************
  // operation sequencer
  // ****************************************
  ufa_state_t state_reg; // current operation
  logic [TIMER_W-1:0] timer_reg; // busy cycles remaining
  logic busy_reg; // busy flag to the controller
  logic write_now; // last program cycle: commit the word
  logic erase_now; // last erase cycle: clear the array

  assign write_now = (state_reg == UFA_PROGRAM) && (timer_reg == '0);
  assign erase_now = (state_reg == UFA_ERASE) && (timer_reg == '0);

  // state steps; program wins if both strobes arrive together
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= UFA_IDLE;
    end else begin
      unique case (state_reg)
        UFA_IDLE: begin
          if (program_req) begin
            state_reg <= UFA_PROGRAM;
          end else if (erase_req) begin
            state_reg <= UFA_ERASE;
          end
        end
        UFA_PROGRAM: begin
          if (write_now) begin
            state_reg <= UFA_RELEASE;
          end
        end
        UFA_ERASE: begin
          if (erase_now) begin
            state_reg <= UFA_RELEASE;
          end
        end
        UFA_RELEASE: begin
          // a strobe left high must not start a second operation
          if (!program_req && !erase_req) begin
            state_reg <= UFA_IDLE;
          end
        end
      endcase
    end
  end

  // busy length counter, loaded at the start of each operation
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      timer_reg <= '0;
    end else if (state_reg == UFA_IDLE && program_req) begin
      timer_reg <= TIMER_W'(PROGRAM_BUSY_CYCLES - 1);
    end else if (state_reg == UFA_IDLE && erase_req) begin
      timer_reg <= TIMER_W'(ERASE_BUSY_CYCLES - 1);
    end else if (timer_reg != '0) begin
      timer_reg <= timer_reg - TIMER_W'(1);
    end
  end

  // busy rises the cycle after the synchronised strobe, 300 ns after the pin,
  // and falls after the programmed span, which the elaboration checks hold at or below the limits
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      busy_reg <= BUSY_RESET;
    end else if (state_reg == UFA_IDLE) begin
      busy_reg <= program_req || erase_req;
    end else if (write_now || erase_now) begin
      busy_reg <= 1'b0;
    end
  end

  assign busy_o = busy_reg;

  // ****************************************
  // storage
  // ****************************************
  logic [DATA_W-1:0] mem_reg [DEPTH]; // flash array in flip-flops
  logic [ADDR_W-1:0] op_addr_reg; // address captured at operation start

  // address latched as the operation starts so a stray shift cannot move it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      op_addr_reg <= '0;
    end else if (state_reg == UFA_IDLE && (program_req || erase_req)) begin
      op_addr_reg <= addr_sync;
    end
  end

  // erase clears the whole array to ones; program can only clear bits,
  // as real flash cells do, so a second program ands into the old word
  generate
    for (genvar w = 0; w < DEPTH; w++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          mem_reg[w] <= '1; // model starts erased
        end else if (erase_now) begin
          mem_reg[w] <= '1;
        end else if (write_now && op_addr_reg == ADDR_W'(w)) begin
          mem_reg[w] <= mem_reg[w] & data_sync;
        end
      end
    end
  endgenerate

  // ****************************************
  // read path
  // ****************************************
  // stored word follows the synchronised address in one core cycle, so the
  // parallel load sees it three core clocks after the address settles
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      read_word_reg <= '1;
    end else begin
      read_word_reg <= mem_reg[addr_sync];
    end
  end

  // address register reloads from the address it already holds
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      addr_hold_reg <= '0;
    end else begin
      addr_hold_reg <= addr_sync;
    end
  end

endmodule

// *** testbench/ufa_flash_checker.sv ***
// port assertions for the flash block
// assumes a bind from the bench top
`timescale 1ns/1ps
module ufa_flash_checker #(
  parameter int PROGRAM_BUSY_CYCLES = 5,
  parameter longint ERASE_BUSY_CYCLES = 8
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic data_clk_i,
  // watched signals
  input wire logic data_shift_i,
  input wire logic data_in_i,
  input wire logic data_out_o,
  input wire logic program_i,
  input wire logic erase_i,
  input wire logic busy_o
);
  logic [31:0] busy_cnt; // cycles of this busy pulse
  logic op_prog; // pulse came from a program
  logic [4:0] sh_cnt = 5'h00; // link side has no reset
  // length and kind of the busy pulse
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !busy_o) begin
      busy_cnt <= 32'h0;
      op_prog <= program_i;
    end else begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end
  // run of shift edges, saturating
  always_ff @(posedge data_clk_i) begin
    sh_cnt <= !data_shift_i ? 5'h00 : (sh_cnt == 5'h1F ? sh_cnt : sh_cnt + 5'h01);
  end
  sequence s_prog_go;
    $rose(program_i) && !erase_i && !busy_o;
  endsequence
  sequence s_erase_go;
    $rose(erase_i) && !program_i && !busy_o;
  endsequence
  chk_prog_busy_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_prog_go |-> ##[1:9] busy_o) else $error("busy late after program");
  chk_erase_busy_rise: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_erase_go |-> ##[1:9] busy_o) else $error("busy late after erase");
  chk_prog_busy_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(busy_o) && op_prog |-> busy_cnt == PROGRAM_BUSY_CYCLES) else $error("program length");
  chk_erase_busy_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(busy_o) && !op_prog |-> busy_cnt == ERASE_BUSY_CYCLES) else $error("erase length");
  chk_busy_min_run: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(busy_o) |-> busy_o [*5]) else $error("busy pulse too short");
  chk_busy_has_cause: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(busy_o) |-> program_i || erase_i) else $error("busy without strobe");
  chk_no_rebusy: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(busy_o) |-> !busy_o [*3]) else $error("busy again while strobe held");
  chk_shift_out_order: assert property (@(posedge data_clk_i) disable iff (!resetn_i)
    sh_cnt >= 5'd16 |-> data_out_o == $past(data_in_i, 16)) else $error("shift order");
endmodule

// *** testbench/ufa_ctl_model.sv ***
// fabric controller model: both register links and the strobes
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module ufa_ctl_model (
  // core side
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic data_out_i,
  // links
  output logic addr_clk_o,
  output logic addr_shift_o,
  output logic addr_in_o,
  output logic data_clk_o,
  output logic data_shift_o,
  output logic data_in_o,
  // strobes
  output logic program_o,
  output logic erase_o
);
  initial begin
    {addr_clk_o, addr_shift_o, addr_in_o, data_clk_o} = 4'h0;
    {data_shift_o, data_in_o, program_o, erase_o} = 4'h0;
  end
  // one link pulse, 60 ns setup then 50 ns high: period 110 ns
  task automatic tick(input bit dat);
    #60;
    if (dat) data_clk_o = 1'b1; else addr_clk_o = 1'b1;
    #50;
    data_clk_o = 1'b0;
    addr_clk_o = 1'b0;
  endtask
  task automatic send_addr(input logic [8:0] a);
    addr_shift_o = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      addr_in_o = a[i];
      tick(1'b0);
    end
    addr_in_o = ~addr_in_o; // released line flips so no stale bit passes
    #500;
  endtask
  // one edge with shift low: the address must reload onto itself
  task automatic reload_addr;
    addr_shift_o = 1'b0;
    tick(1'b0);
    addr_shift_o = 1'b1;
    #500;
  endtask
  task automatic send_word(input logic [15:0] w);
    data_shift_o = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      data_in_o = w[i];
      tick(1'b1);
    end
    data_in_o = ~data_in_o;
  endtask
  task automatic get_word(output logic [15:0] w);
    data_shift_o = 1'b0;
    tick(1'b1); // load edge
    data_shift_o = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      w[i] = data_out_i;
      if (i > 0) tick(1'b1);
    end
  endtask
  // strobes (bit 0 program, bit 1 erase), wait busy, hold past its fall
  task automatic run_op(input bit [1:0] kind, output int busy_cyc);
    int n;
    n = 0;
    busy_cyc = 0;
    program_o = kind[0];
    erase_o = kind[1];
    while (busy_i !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    while (busy_i === 1'b1 && busy_cyc < 100) begin
      @(negedge clk_i);
      busy_cyc++;
    end
    #30;
    program_o = 1'b0;
    erase_o = 1'b0;
    #500;
  endtask
endmodule

// *** testbench/tb_user_flash_access_timing.sv ***
// self-checking bench for the flash block
// assumes ufa_ctl_model drives the links and strobes
`timescale 1ns/1ps
module tb_user_flash_access_timing;
  import ufa_pkg::*;
  localparam int PB = 5; // short program pulse
  localparam longint EB = 8; // short erase pulse
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic a_clk, a_sh, a_in, d_clk, d_sh, d_in, d_out, prg, ers, busy;
  int fails = 0;
  int checks = 0;
  logic [15:0] mem [int]; // expected contents, absent means erased
  ufa_flash #(.PROGRAM_BUSY_CYCLES(PB), .ERASE_BUSY_CYCLES(EB)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_clk_i(a_clk), .addr_shift_i(a_sh),
    .addr_in_i(a_in), .data_clk_i(d_clk), .data_shift_i(d_sh), .data_in_i(d_in),
    .data_out_o(d_out), .program_i(prg), .erase_i(ers), .busy_o(busy));
  ufa_ctl_model u_ctl (
    .clk_i(clk_i), .busy_i(busy), .data_out_i(d_out), .addr_clk_o(a_clk),
    .addr_shift_o(a_sh), .addr_in_o(a_in), .data_clk_o(d_clk), .data_shift_o(d_sh),
    .data_in_o(d_in), .program_o(prg), .erase_o(ers));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [15:0] exp_word(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [8:0] a);
    logic [15:0] w;
    u_ctl.send_addr(a);
    u_ctl.reload_addr();
    u_ctl.get_word(w);
    check(64'(w), 64'(exp_word(a)));
  endtask
  task automatic prog(input logic [8:0] a, input logic [15:0] w);
    int c;
    u_ctl.send_addr(a);
    u_ctl.send_word(w);
    u_ctl.run_op(2'b01, c);
    check(64'(c), 64'(PB));
    mem[a] = exp_word(a) & w;
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    logic [8:0] a;
    int c;
    void'($urandom(32'ha54c9a95));
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(9'h000);
    prog(9'h1FF, 16'h0000);
    rd(9'h1FF);
    for (int i = 0; i < 5; i++) begin
      a = 9'($urandom);
      prog(a, 16'($urandom));
      prog(a, 16'($urandom)); // bits only clear
      rd(a);
    end
    u_ctl.run_op(2'b10, c);
    check(64'(c), 64'(EB));
    mem.delete();
    rd(a);
    rd(9'h1FF);
    // both strobes together: program wins, no erase
    u_ctl.send_addr(9'h0A5);
    u_ctl.send_word(16'h5A5A);
    u_ctl.run_op(2'b11, c);
    check(64'(c), 64'(PB));
    mem[9'h0A5] = exp_word(9'h0A5) & 16'h5A5A;
    rd(9'h0A5);
    prog(a, 16'($urandom));
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    mem.delete();
    rd(a);
    wrap_up();
  end
  initial begin
    #2_000_000;
    fails++;
    wrap_up();
  end
endmodule
bind ufa_flash ufa_flash_checker #(.PROGRAM_BUSY_CYCLES(PROGRAM_BUSY_CYCLES),
  .ERASE_BUSY_CYCLES(ERASE_BUSY_CYCLES)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .data_clk_i(data_clk_i), .data_shift_i(data_shift_i), .data_in_i(data_in_i),
  .data_out_o(data_out_o), .program_i(program_i), .erase_i(erase_i), .busy_o(busy_o));
